// File: core/rps_pkg.sv
// reset phase sequencer: shared constants, phase and sub-step codes
// assumes a single 20 MHz clock; all times are converted to its cycles
package rps_pkg;

  // ----------------------------------------------------------------------
  // clock and timing
  // ----------------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_PS   = 50000;
  localparam int unsigned FAST_INTERNAL_OSC_PERIOD_PS  = 62500;
  localparam int unsigned REG_MIN_NS      = 200000;
  localparam int unsigned P0_MIN_NS       = 18000;
  localparam int unsigned P1_MIN_FAST_INTERNAL_OSC     = 10;
  localparam int unsigned P2_MIN_FAST_INTERNAL_OSC     = 8;
  localparam int unsigned CYC_PER_RECORD  = 8;
  localparam int unsigned RELEASE_CYC     = 40;
  localparam int unsigned EXT_LONG_CYC    = 320;

  localparam int unsigned CNT_W = 13;
  localparam int unsigned REC_W = 8;
  localparam int unsigned PAD_W = 9;

  typedef logic [CNT_W-1:0] rps_cnt_type;
  typedef logic [REC_W-1:0] rps_rec_type;

  // least times round up to whole cycles
  function automatic rps_cnt_type rps_ceil_cyc(input int unsigned ps);
    return rps_cnt_type'((ps + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS);
  endfunction

  localparam rps_cnt_type REG_MIN_CYC = rps_ceil_cyc(REG_MIN_NS * 1000);
  localparam rps_cnt_type P0_MIN_CYC  = rps_ceil_cyc(P0_MIN_NS * 1000);
  localparam rps_cnt_type P1_MIN_CYC  =
    rps_ceil_cyc(P1_MIN_FAST_INTERNAL_OSC * FAST_INTERNAL_OSC_PERIOD_PS);
  localparam rps_cnt_type P2_MIN_CYC  =
    rps_ceil_cyc(P2_MIN_FAST_INTERNAL_OSC * FAST_INTERNAL_OSC_PERIOD_PS);
  localparam rps_cnt_type REL_CYC     = rps_cnt_type'(RELEASE_CYC);

  // ----------------------------------------------------------------------
  // states
  // ----------------------------------------------------------------------
  typedef enum logic [2:0] {
    PH_REG  = 3'h0,
    PH_P0   = 3'h1,
    PH_P1   = 3'h2,
    PH_P2   = 3'h3,
    PH_P3   = 3'h4,
    PH_IDLE = 3'h5
  } rps_phase_type;

  typedef enum logic [1:0] {
    SUB_LOAD  = 2'h0,
    SUB_DRIVE = 2'h1,
    SUB_WAIT  = 2'h2
  } rps_sub_type;

endpackage

// File: core/rps_sub_if.sv
// links between the sequencer and its phase timer and pad monitor
// assumes all three parties sit on the same clock
`timescale 1ns/1ns
interface rps_sub_if;
  logic               tmr_start;
  rps_pkg::rps_cnt_type tmr_load;
  logic               tmr_done;
  logic               pad_low;
  logic               pad_watch;
  logic               pad_long;

  modport seq (output tmr_start, tmr_load, pad_low, pad_watch,
               input  tmr_done, pad_long);
  modport tmr (input  tmr_start, tmr_load, output tmr_done);
  modport pad (input  pad_low, pad_watch, output pad_long);
endinterface

// File: core/rps_timer.sv
// phase minimum-duration timer: load on start, done once count runs out
// assumes start is a one-cycle pulse; done is stale in the start cycle
`timescale 1ns/1ns
module rps_timer (
  // clock and reset
  input  wire logic i_clk,
  input  wire logic i_rst_n,
  // control
  rps_sub_if.tmr    bus
);
  typedef struct packed {
    rps_pkg::rps_cnt_type cnt;
    logic                 done;
  } rps_tmr_st_type;

  rps_tmr_st_type s_q;
  rps_tmr_st_type s_d;

  always_comb begin
    s_d = s_q;
    if (bus.tmr_start) begin
      s_d.cnt = bus.tmr_load;
    end else if (s_q.cnt != '0) begin
      s_d.cnt = s_q.cnt - rps_pkg::rps_cnt_type'(1);
    end
    s_d.done = (s_d.cnt == '0);
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign bus.tmr_done = s_q.done;
endmodule

// File: core/rps_pad_mon.sv
// external reset pad monitor: counts low cycles after the pad is released
// assumes pad_watch is high only while the device no longer pulls the pad
`timescale 1ns/1ns
module rps_pad_mon (
  // clock and reset
  input  wire logic i_clk,
  input  wire logic i_rst_n,
  // pad view
  rps_sub_if.pad    bus
);
  typedef struct packed {
    logic [rps_pkg::PAD_W-1:0] cnt;
    logic                      long_low;
  } rps_pad_st_type;

  rps_pad_st_type s_q;
  rps_pad_st_type s_d;

  always_comb begin
    s_d = s_q;
    if (bus.pad_watch && bus.pad_low) begin
      // saturate so a pad stuck low cannot wrap back under the limit
      if (s_q.cnt != '1) begin
        s_d.cnt = s_q.cnt + 1'b1;
      end
    end else begin
      s_d.cnt = '0;
    end
    s_d.long_low = (s_d.cnt > rps_pkg::PAD_W'(rps_pkg::EXT_LONG_CYC));
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign bus.pad_long = s_q.long_low;
endmodule

// File: core/rps_seq.sv
// reset phase sequencer top: regulator start-up, phases 0..3, idle
// assumes event inputs are synchronous levels or pulses on i_clk
// Notes on behaviour
// R1: destructive reset or power-on goes to regulator start-up, waits stable
// R2: phase 0 ends after power good, oscillator running, destructive done
// R3: phase 1 entered after phase 0, or at once from 2, 3 or idle
// R4: phase 1 ends after functional sources done and ten oscillator cycles
// R5: phase 2 is entered only from phase 1
// R6: phase 2 initialises flash, lasts at least eight oscillator cycles
// R7: phase 3 entered from phase 2 or idle, on trimmed oscillator
// R8: phase 3 fetches each config record, eight cycles per record
// R9: phase 3 holds while the external reset input stays low
// R10: each phase waits its minimum time and all its tasks
// R11: destructive reset runs phases 0, 1, 2, 3 in order
// R12: external, long, functional resets run phases 1, 2, 3
// R13: short select or short reset starts straight at phase 3
// R14: at idle leave reset mode, run in default run mode
// R15: ordinary pins held high impedance until idle
// R16: two boot pins stay active during reset, boot use only
// R17: reset pad pulled low until the 40-cycle release count ends
// R18: external flag set only if pad held low beyond 320 cycles
// R19: external reset in normal execution sets its status at once
// R20: record count is an input, phase 3 length scales with it
`timescale 1ns/1ns
module rps_seq (
  // clock and reset
  input  wire logic                 i_clk,
  input  wire logic                 i_rst_n,
  // reset events
  input  wire logic                 i_destructive_rst,
  input  wire logic                 i_functional_rst,
  input  wire logic                 i_long_rst,
  input  wire logic                 i_short_rst,
  input  wire logic                 i_short_sequence_select,
  // task status
  input  wire logic                 i_regulator_stable,
  input  wire logic                 i_power_good_indication,
  input  wire logic                 i_fast_internal_osc_run,
  input  wire logic                 i_destructive_pending,
  input  wire logic                 i_functional_pending,
  input  wire logic                 i_flash_init_done,
  input  wire rps_pkg::rps_rec_type i_record_count,
  input  wire logic                 i_flag_clear,
  // external reset pad
  input  wire logic                 i_rst_pad_in,
  output logic                      o_rst_pad_out,
  output logic                      o_rst_pad_oe,
  // status
  output rps_pkg::rps_phase_type    o_phase,
  output logic                      o_reset_mode,
  output logic                      o_default_run_mode,
  output logic                      o_pins_hiz,
  output logic                      o_boot_pins_en,
  output logic                      o_ext_reset_flag,
  output logic                      o_ext_reset_status,
  // flash and config records
  output logic                      o_flash_init_req,
  output logic                      o_record_fetch,
  output rps_pkg::rps_rec_type      o_record_index
);

  // ----------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------
  typedef struct packed {
    rps_pkg::rps_phase_type phase;
    rps_pkg::rps_sub_type   sub;
    logic                   start;
    rps_pkg::rps_cnt_type   load;
    rps_pkg::rps_rec_type   rec_total;
    rps_pkg::rps_rec_type   rec_idx;
    logic [2:0]             rec_cyc;
    logic                   fetch;
    rps_pkg::rps_rec_type   fetch_idx;
    logic                   pad_oe;
    logic                   hiz;
    logic                   run;
    logic                   flash_req;
    logic                   ext_flag;
    logic                   ext_status;
  } rps_seq_st_type;

  localparam rps_seq_st_type RST_ST = '{
    phase: rps_pkg::PH_REG, sub: rps_pkg::SUB_LOAD, start: 1'b1,
    load: rps_pkg::REG_MIN_CYC, rec_total: '0, rec_idx: '0,
    rec_cyc: '0, fetch: 1'b0, fetch_idx: '0, pad_oe: 1'b1, hiz: 1'b1,
    run: 1'b0, flash_req: 1'b0, ext_flag: 1'b0, ext_status: 1'b0};

  rps_seq_st_type s_q;
  rps_seq_st_type s_d;
  rps_sub_if      sub_if ();

  logic tdone;
  logic ext_evt;

  // minimum stay per phase; phase 3 is paced by its record counter
  function automatic rps_pkg::rps_cnt_type phase_min(
      input rps_pkg::rps_phase_type ph);
    case (ph)
      rps_pkg::PH_REG: phase_min = rps_pkg::REG_MIN_CYC;
      rps_pkg::PH_P0:  phase_min = rps_pkg::P0_MIN_CYC;
      rps_pkg::PH_P1:  phase_min = rps_pkg::P1_MIN_CYC;
      rps_pkg::PH_P2:  phase_min = rps_pkg::P2_MIN_CYC;
      default:         phase_min = rps_pkg::rps_cnt_type'(1);
    endcase
  endfunction

  function automatic rps_seq_st_type enter(input rps_seq_st_type st,
      input rps_pkg::rps_phase_type ph, input rps_pkg::rps_rec_type recs);
    enter           = st;
    enter.phase     = ph;
    enter.sub       = rps_pkg::SUB_LOAD;
    enter.start     = 1'b1;
    enter.load      = phase_min(ph);
    enter.rec_total = recs;
    enter.rec_idx   = '0;
    enter.rec_cyc   = '0;
    enter.pad_oe    = (ph != rps_pkg::PH_IDLE);
  endfunction

  // ----------------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------------
  // the timer's done is from the previous phase while start is pending
  assign tdone   = sub_if.tmr_done && !s_q.start;
  assign ext_evt = (s_q.phase == rps_pkg::PH_IDLE) && !i_rst_pad_in;

  always_comb begin
    s_d       = s_q;
    s_d.start = 1'b0;
    s_d.fetch = 1'b0;
    case (s_q.phase)
      rps_pkg::PH_REG: begin
        if (tdone && i_regulator_stable) begin // R1 R10
          s_d = enter(s_d, rps_pkg::PH_P0, i_record_count);
        end
      end
      rps_pkg::PH_P0: begin
        if (tdone && i_power_good_indication && i_fast_internal_osc_run &&
            !i_destructive_pending) begin // R2 R11
          s_d = enter(s_d, rps_pkg::PH_P1, i_record_count);
        end
      end
      rps_pkg::PH_P1: begin
        if (tdone && !i_functional_pending) begin // R4 R5 R10
          s_d = enter(s_d, rps_pkg::PH_P2, i_record_count);
        end
      end
      rps_pkg::PH_P2: begin
        if (tdone && i_flash_init_done) begin // R6 R7
          s_d = enter(s_d, rps_pkg::PH_P3, i_record_count); // R20
        end
      end
      rps_pkg::PH_P3: begin
        case (s_q.sub)
          rps_pkg::SUB_LOAD: begin
            if (s_q.rec_idx == s_q.rec_total) begin
              s_d.sub   = rps_pkg::SUB_DRIVE;
              s_d.start = 1'b1;
              s_d.load  = rps_pkg::REL_CYC;
            end else begin // R8
              s_d.rec_cyc = s_q.rec_cyc + 3'h1;
              if (s_q.rec_cyc == 3'h0) begin
                s_d.fetch     = 1'b1;
                s_d.fetch_idx = s_q.rec_idx;
              end
              if (s_q.rec_cyc == 3'(rps_pkg::CYC_PER_RECORD - 1)) begin
                s_d.rec_idx = s_q.rec_idx + 1'b1;
              end
            end
          end
          rps_pkg::SUB_DRIVE: begin
            if (tdone) begin // R17
              s_d.sub    = rps_pkg::SUB_WAIT;
              s_d.pad_oe = 1'b0;
            end
          end
          rps_pkg::SUB_WAIT: begin
            if (i_rst_pad_in) begin // R9
              s_d = enter(s_d, rps_pkg::PH_IDLE, s_q.rec_total);
            end
          end
          default: begin
            s_d.sub = rps_pkg::SUB_LOAD;
          end
        endcase
      end
      rps_pkg::PH_IDLE: begin
      end
      default: begin
        s_d = enter(s_d, rps_pkg::PH_REG, s_q.rec_total);
      end
    endcase

    // reset events: destructive first, then the functional family
    if (i_destructive_rst) begin // R1 R11
      s_d = enter(s_d, rps_pkg::PH_REG, s_q.rec_total);
    end else if ((s_q.phase == rps_pkg::PH_P2 ||
                  s_q.phase == rps_pkg::PH_P3 ||
                  s_q.phase == rps_pkg::PH_IDLE) &&
                 (ext_evt || i_long_rst ||
                  (i_functional_rst && !i_short_sequence_select))) begin
      s_d = enter(s_d, rps_pkg::PH_P1, s_q.rec_total); // R3 R12
    end else if (s_q.phase == rps_pkg::PH_IDLE &&
                 (i_short_rst ||
                  (i_functional_rst && i_short_sequence_select))) begin
      s_d = enter(s_d, rps_pkg::PH_P3, i_record_count); // R13
    end

    s_d.hiz       = (s_d.phase != rps_pkg::PH_IDLE); // R15 R16
    s_d.run       = (s_d.phase == rps_pkg::PH_IDLE); // R14
    s_d.flash_req = (s_d.phase == rps_pkg::PH_P2); // R6

    // set wins over a clear in the same cycle
    if (sub_if.pad_long && s_q.phase == rps_pkg::PH_P3) begin // R18
      s_d.ext_flag = 1'b1;
    end else if (i_flag_clear) begin
      s_d.ext_flag = 1'b0;
    end
    if (ext_evt) begin // R19
      s_d.ext_status = 1'b1;
    end else if (i_flag_clear) begin
      s_d.ext_status = 1'b0;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      s_q <= RST_ST;
    end else begin
      s_q <= s_d;
    end
  end

  // ----------------------------------------------------------------------
  // helpers and outputs
  // ----------------------------------------------------------------------
  assign sub_if.tmr_start = s_q.start;
  assign sub_if.tmr_load  = s_q.load;
  assign sub_if.pad_low   = !i_rst_pad_in;
  // only count once released; our own pull-down must not set the flag
  assign sub_if.pad_watch = (s_q.phase == rps_pkg::PH_P3) &&
                            (s_q.sub == rps_pkg::SUB_WAIT);

  rps_timer u_timer (
    .i_clk   (i_clk),
    .i_rst_n (i_rst_n),
    .bus     (sub_if.tmr)
  );

  rps_pad_mon u_pad (
    .i_clk   (i_clk),
    .i_rst_n (i_rst_n),
    .bus     (sub_if.pad)
  );

  assign o_rst_pad_out      = 1'b0;
  assign o_rst_pad_oe       = s_q.pad_oe;
  assign o_phase            = s_q.phase;
  assign o_reset_mode       = s_q.hiz;
  assign o_default_run_mode = s_q.run;
  assign o_pins_hiz         = s_q.hiz;
  assign o_boot_pins_en     = s_q.hiz;
  assign o_ext_reset_flag   = s_q.ext_flag;
  assign o_ext_reset_status = s_q.ext_status;
  assign o_flash_init_req   = s_q.flash_req;
  assign o_record_fetch     = s_q.fetch;
  assign o_record_index     = s_q.fetch_idx;

  // ----------------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);

  a_reg_on_destr: assert property ( // R1
    i_destructive_rst |=> o_phase == rps_pkg::PH_REG)
    else $error("destructive reset did not reach regulator start-up");
  a_p0_exit_ok: assert property ( // R2
    (o_phase == rps_pkg::PH_P1 && $past(o_phase) == rps_pkg::PH_P0) |->
    $past(i_power_good_indication && i_fast_internal_osc_run &&
          !i_destructive_pending))
    else $error("phase 0 left before its tasks ended");
  a_p1_entry_src: assert property ( // R3
    (o_phase == rps_pkg::PH_P1 && $past(o_phase) != rps_pkg::PH_P1) |->
    $past(o_phase) inside {rps_pkg::PH_P0, rps_pkg::PH_P2,
                           rps_pkg::PH_P3, rps_pkg::PH_IDLE})
    else $error("phase 1 entered from an illegal phase");
  a_p1_min_time: assert property ( // R4
    (o_phase == rps_pkg::PH_P2 && $past(o_phase) == rps_pkg::PH_P1) |->
    $past(o_phase, 13) == rps_pkg::PH_P1)
    else $error("phase 1 shorter than its minimum");
  a_p2_entry_src: assert property ( // R5
    (o_phase == rps_pkg::PH_P2 && $past(o_phase) != rps_pkg::PH_P2) |->
    $past(o_phase) == rps_pkg::PH_P1)
    else $error("phase 2 entered from other than phase 1");
  a_p2_min_time: assert property ( // R6
    (o_phase == rps_pkg::PH_P3 && $past(o_phase) == rps_pkg::PH_P2) |->
    $past(o_phase, 10) == rps_pkg::PH_P2)
    else $error("phase 2 shorter than its minimum");
  a_p3_entry_src: assert property ( // R7
    (o_phase == rps_pkg::PH_P3 && $past(o_phase) != rps_pkg::PH_P3) |->
    $past(o_phase) inside {rps_pkg::PH_P2, rps_pkg::PH_IDLE})
    else $error("phase 3 entered from an illegal phase");
  a_record_pace: assert property ( // R8
    o_record_fetch |=> !o_record_fetch [*7])
    else $error("config records fetched faster than one per 8 cycles");
  a_p3_ext_hold: assert property ( // R9
    (o_phase == rps_pkg::PH_P3 && !o_rst_pad_oe && !i_rst_pad_in) |=>
    o_phase != rps_pkg::PH_IDLE)
    else $error("idle reached while external reset still low");
  a_short_entry: assert property ( // R13
    (o_phase == rps_pkg::PH_P3 && $past(o_phase) == rps_pkg::PH_IDLE) |->
    $past(i_short_rst || (i_functional_rst && i_short_sequence_select)))
    else $error("phase 3 entered from idle without a short request");
  a_idle_pins_on: assert property ( // R14 R15
    o_default_run_mode |-> !o_pins_hiz && o_phase == rps_pkg::PH_IDLE)
    else $error("run mode with pins still released or not idle");
  a_pad_release: assert property ( // R17
    ($fell(o_rst_pad_oe) && o_phase == rps_pkg::PH_P3) |->
    $past(o_rst_pad_oe, 40))
    else $error("reset pad released before the release count");
  a_ext_flag_set: assert property ( // R18
    $rose(o_ext_reset_flag) |-> $past(!i_rst_pad_in && !o_rst_pad_oe))
    else $error("external flag set without the pad held low");
  a_ext_status: assert property ( // R19
    (o_phase == rps_pkg::PH_IDLE && !i_rst_pad_in) |=> o_ext_reset_status)
    else $error("external reset in run mode did not set its status");

  c_reach_idle: cover property (
    $past(o_phase) == rps_pkg::PH_P3 && o_phase == rps_pkg::PH_IDLE);
  c_ext_flag: cover property ($rose(o_ext_reset_flag));
  c_short_seq: cover property (
    $past(o_phase) == rps_pkg::PH_IDLE && o_phase == rps_pkg::PH_P3);
  c_func_seq: cover property (
    $past(o_phase) == rps_pkg::PH_IDLE && o_phase == rps_pkg::PH_P1);
endmodule

// File: tb/rps_ext_src.sv
// external reset source model: pulls the reset pad low for a set count
// assumes an open-drain pad whose pull-up is resolved by the bench
`timescale 1ns/1ns
module rps_ext_src (
  // clock and reset
  input  wire logic        i_clk,
  input  wire logic        i_rst_n,
  // command
  input  wire logic        i_go,
  input  wire logic [11:0] i_len,
  // pad
  output logic             o_pull_low
);
  logic [11:0] cnt_q;

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      cnt_q <= 12'h000;
    end else if (i_go) begin
      cnt_q <= i_len;
    end else if (cnt_q != 12'h000) begin
      cnt_q <= cnt_q - 12'h001;
    end
  end
  // open drain: released means the pull-up wins, never a held value
  assign o_pull_low = (cnt_q != 12'h000);
endmodule

// File: tb/tb.sv
// self-checking bench for the reset phase sequencer
// assumes rps_seq alone, pad resolved here with a pull-up
`timescale 1ns/1ns
`define CHK(g, e, m) begin samples_checked++; if ((g) !== (e)) begin \
  mismatches++; $display("[FAIL] %0t %s", $time, m); end end
module tb;
  logic i_clk = 1'b0;
  logic rst_n = 1'b0;
  logic dstr = 1'b0, func = 1'b0, lng = 1'b0, shrt = 1'b0, sel = 1'b0;
  logic reg_st = 1'b0, pg = 1'b1, osc = 1'b1, dpend = 1'b0;
  logic fpend = 1'b0, fdone = 1'b1, fclr = 1'b0, ext_go = 1'b0;
  logic [7:0]  rec_cnt = 8'h03;
  logic [11:0] ext_len = 12'h000;
  logic pull, oe, pad_out, reset_mode, run_mode, hiz, boot_en;
  logic ext_flag, ext_status, flash_req, rec_fetch;
  logic [7:0] rec_idx;
  rps_pkg::rps_phase_type phase;
  rps_pkg::rps_phase_type prev = rps_pkg::PH_REG;
  int mismatches = 0, samples_checked = 0, cyc = 0;
  int cur = 0, rec_n = 0, oe_cnt = 0;
  int dur [8];
  logic [17:0] path = 18'h00000;
  logic pad;
  // pull-up: pad is low only while someone pulls it
  assign pad = !(oe | pull);

  always #25 i_clk = ~i_clk;

  rps_seq DUT (.i_clk(i_clk), .i_rst_n(rst_n), .i_destructive_rst(dstr),
    .i_functional_rst(func), .i_long_rst(lng), .i_short_rst(shrt),
    .i_short_sequence_select(sel), .i_regulator_stable(reg_st),
    .i_power_good_indication(pg), .i_fast_internal_osc_run(osc),
    .i_destructive_pending(dpend), .i_functional_pending(fpend),
    .i_flash_init_done(fdone), .i_record_count(rec_cnt),
    .i_flag_clear(fclr), .i_rst_pad_in(pad), .o_rst_pad_out(pad_out),
    .o_rst_pad_oe(oe), .o_phase(phase), .o_reset_mode(reset_mode),
    .o_default_run_mode(run_mode), .o_pins_hiz(hiz),
    .o_boot_pins_en(boot_en), .o_ext_reset_flag(ext_flag),
    .o_ext_reset_status(ext_status), .o_flash_init_req(flash_req),
    .o_record_fetch(rec_fetch), .o_record_index(rec_idx));

  rps_ext_src ext (.i_clk(i_clk), .i_rst_n(rst_n), .i_go(ext_go),
    .i_len(ext_len), .o_pull_low(pull));

  // ----------------------------------------------------------------------
  // monitor: phase path, stay lengths, records
  // ----------------------------------------------------------------------
  always @(negedge i_clk) begin
    if (phase !== prev) begin
      dur[int'(prev)] = cur;
      cur = 0;
      path = {path[14:0], phase};
      if (phase === rps_pkg::PH_P2) `CHK(prev, rps_pkg::PH_P1, "p2 entry")
      if (phase === rps_pkg::PH_P3) begin
        rec_n = 0;
        oe_cnt = 0;
      end
    end
    cur++;
    prev = phase;
    if (phase === rps_pkg::PH_P3 && oe === 1'b1) oe_cnt++;
    `CHK(flash_req, phase === rps_pkg::PH_P2, "flash req")
    `CHK(pad_out, 1'b0, "pad level")
    if (rec_fetch === 1'b1) begin
      `CHK(rec_idx, rec_n[7:0], "record index")
      rec_n++;
    end
    // outputs register on the same edge as the phase; first two cycles of each stay skipped
    if (cur >= 3 && rst_n) begin
      `CHK(hiz, phase !== rps_pkg::PH_IDLE, "pin tristate")
      `CHK(boot_en, phase !== rps_pkg::PH_IDLE, "boot pins")
      `CHK(run_mode, phase === rps_pkg::PH_IDLE, "run mode")
      `CHK(reset_mode, phase !== rps_pkg::PH_IDLE, "reset mode")
    end
  end

  always @(posedge i_clk) begin
    cyc++;
    if (cyc == 30000) begin
      mismatches++;
      $display("[FAIL] %0t timeout", $time);
      finish_test();
    end
  end

  function automatic int min_c(input int ps);
    return (ps + 49999) / 50000 + 1;
  endfunction

  function automatic logic [17:0] exp_path(input int k);
    case (k)
      0: return {rps_pkg::PH_REG, rps_pkg::PH_P0, rps_pkg::PH_P1,
                 rps_pkg::PH_P2, rps_pkg::PH_P3, rps_pkg::PH_IDLE};
      3, 4: return {12'h000, rps_pkg::PH_P3, rps_pkg::PH_IDLE};
      default: return {6'h00, rps_pkg::PH_P1, rps_pkg::PH_P2,
                       rps_pkg::PH_P3, rps_pkg::PH_IDLE};
    endcase
  endfunction

  task automatic tick(input int n);
    repeat (n) @(posedge i_clk);
  endtask

  task automatic wait_ph(input rps_pkg::rps_phase_type p, input int lim);
    int k;
    k = 0;
    while (phase !== p && k < lim) begin
      @(negedge i_clk);
      k++;
    end
    `CHK(phase, p, "phase not reached")
  endtask

  task automatic chk_min(input bit full, input int h);
    if (full) begin
      `CHK(dur[0] >= min_c(rps_pkg::REG_MIN_NS * 1000), 1'b1, "reg")
      `CHK(dur[1] >= min_c(rps_pkg::P0_MIN_NS * 1000), 1'b1, "p0")
    end
    `CHK(dur[2] >= min_c(10 * 62500) && dur[2] > h, 1'b1, "p1")
    `CHK(dur[3] >= min_c(8 * 62500) && dur[3] > h, 1'b1, "p2")
  endtask

  // ----------------------------------------------------------------------
  // one reset request from idle back to idle
  // ----------------------------------------------------------------------
  task automatic run(input int k, input int h, input int len);
    logic [7:0] n;
    int w;
    n = 8'($urandom_range(0, 5));
    @(posedge i_clk);
    path = 18'h00000;
    rec_cnt <= n;
    ext_len <= 12'(len);
    fpend <= (h > 0);
    fdone <= (h == 0);
    dpend <= (k == 0);
    pg <= (k != 0);
    osc <= (k != 0);
    case (k)
      0: dstr <= 1'b1;
      1: func <= 1'b1;
      2: lng <= 1'b1;
      3: shrt <= 1'b1;
      4: begin
        func <= 1'b1;
        sel <= 1'b1;
      end
      default: ext_go <= 1'b1;
    endcase
    @(posedge i_clk);
    {dstr, func, lng, shrt, sel, ext_go} <= 6'h00;
    // the phase flop updates in this time step; look after it settles
    @(negedge i_clk);
    if (k == 0) begin
      // phase 0 must wait for each of its tasks, not just its minimum
      wait_ph(rps_pkg::PH_P0, 4100);
      tick(370);
      pg <= 1'b1;
      tick(15);
      osc <= 1'b1;
      tick(15);
      dpend <= 1'b0;
    end
    if (k == 5) begin
      wait_ph(rps_pkg::PH_P1, 4);
      `CHK(ext_status, 1'b1, "ext status")
    end
    if (h > 0) begin
      tick(h);
      fpend <= 1'b0;
      wait_ph(rps_pkg::PH_P2, 60);
      tick(h);
      fdone <= 1'b1;
    end
    if (len > 500) begin
      wait_ph(rps_pkg::PH_P3, 100);
      w = 0;
      while (oe !== 1'b0 && w < 200) begin
        @(negedge i_clk);
        w++;
      end
      tick(330);
      `CHK(phase, rps_pkg::PH_P3, "held by pad")
      `CHK(ext_flag, 1'b1, "long pad flag")
    end
    wait_ph(rps_pkg::PH_IDLE, 6000);
    tick(4);
    `CHK(path, exp_path(k), "phase path")
    `CHK(rec_n, int'(n), "record count")
    `CHK(oe_cnt >= 8 * int'(n) + 40, 1'b1, "pad drive")
    if (k < 3 || k == 5) chk_min(k == 0, h);
    if (k == 0) `CHK(dur[1] > 400, 1'b1, "p0 tasks")
    `CHK(ext_flag, len > 500, "ext flag")
    $display("test %0d done", k);
  endtask

  task automatic finish_test();
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  initial begin
    void'($urandom(43));
    tick(9);
    @(negedge i_clk);
    `CHK({phase, oe, hiz, run_mode}, {rps_pkg::PH_REG, 3'h6}, "reset")
    `CHK({reset_mode, pad_out}, 2'h2, "reset mode")
    @(posedge i_clk);
    rst_n <= 1'b1;
    // regulator slow to settle: stay must follow it, not the minimum
    tick(4500);
    reg_st <= 1'b1;
    wait_ph(rps_pkg::PH_IDLE, 6000);
    tick(4);
    `CHK(dur[0] > 4500, 1'b1, "regulator wait")
    chk_min(1'b1, 0);
    `CHK(rec_n, 3, "power-on records")
    `CHK(ext_flag, 1'b0, "no flag")
    $display("test power-on done");
    run(1, 20 + int'($urandom_range(0, 20)), 0);
    run(2, 0, 0);
    run(3, 0, 0);
    run(4, 0, 0);
    run(5, 0, 60);
    run(5, 0, 900);
    @(posedge i_clk);
    fclr <= 1'b1;
    @(posedge i_clk);
    fclr <= 1'b0;
    tick(2);
    `CHK({ext_flag, ext_status}, 2'h0, "flag clear")
    run(0, 0, 0);
    finish_test();
  end
endmodule
